// file: hdl/mea_cfg_space.sv
// Purpose: 256 x 8 configuration register space with region decode
// Assumes: Single writer, the management slave; hardware reads a second port
// Notes:   Identification and reserved test locations are read-only
`timescale 1ns/1ps
`include "mea_regs.svh"
module mea_cfg_space #(
	parameter logic [7:0] CHIP_ID0 = 8'hA5, // Arbitrary value
	parameter logic [7:0] CHIP_ID1 = 8'h10  // Arbitrary value
) (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic [7:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata,
	input  wire logic [7:0] i_hw_addr,
	output logic      [7:0] o_hw_data
);
	import mea_pkg::*;

	mea_rf_t q;
	mea_rf_t n;

	function automatic mea_region_t region(input logic [7:0] a);
		if (a <= `MEA_A_CHIP_END) region = rg_chip;
		else if (a <= `MEA_A_GLB_END) region = rg_glb;
		else if (a <= `MEA_A_PWR_END) region = rg_pwr;
		else if (a <= `MEA_A_PORT_END) begin
			if (a[3:0] <= `MEA_A_PCTL_END) region = rg_pctl;
			else if (a[3:0] <= `MEA_A_PTST_END) region = rg_ptst;
			else region = rg_pstat;
		end
		else if (a <= `MEA_A_RSV0_END) region = rg_rsvd;
		else if (a <= `MEA_A_STA_END) region = rg_sta;
		else if (a <= `MEA_A_ICTL_END) region = rg_ictl;
		else if (a <= `MEA_A_IDAT_END) region = rg_idat;
		else if (a <= `MEA_A_RSV1_END) region = rg_rsvd;
		else if (a <= `MEA_A_PINT_END) region = rg_pint;
		else if (a <= `MEA_A_RSV2_END) region = rg_rsvd;
		else if (a <= `MEA_A_GLX_END) region = rg_glx;
		else if (a == `MEA_A_SELFTEST) region = rg_self;
		else if (a <= `MEA_A_QUEUE_END) region = rg_queue;
		else if (a <= `MEA_A_TOS_END) region = rg_tos;
		else if (a <= `MEA_A_RSV3_END) region = rg_rsvd;
		else if (a[3:0] == `MEA_A_XTST_NIB) region = rg_ptst;
		else region = rg_xctl;
	endfunction : region

	function automatic logic locked(input mea_region_t r);
		locked = (r == rg_chip) || (r == rg_ptst) || (r == rg_rsvd);
	endfunction : locked

	always_comb begin
		n = q;
		if (i_wr && !locked(region(i_addr))) begin
			n.mem[i_addr] = i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	always_comb begin
		if (region(i_addr) == rg_chip) begin
			o_rdata = (i_addr == `MEA_A_CHIP0) ? CHIP_ID0 : CHIP_ID1;
		end else if (locked(region(i_addr))) begin
			o_rdata = '0;
		end else begin
			o_rdata = q.mem[i_addr];
		end
	end

	assign o_hw_data = q.mem[i_hw_addr];

	property p_wr_stores;
		@(posedge i_clk) disable iff (!i_arst_n)
		(i_wr && !locked(region(i_addr))) |=> (q.mem[$past(i_addr)] == $past(i_wdata));
	endproperty
	a_wr_stores: assert property (p_wr_stores) else $error("write not stored");

	property p_test_locked;
		@(posedge i_clk) disable iff (!i_arst_n)
		(i_wr && region(i_addr) == rg_ptst) |=> $stable(q.mem[$past(i_addr)]);
	endproperty
	a_test_locked: assert property (p_test_locked) else $error("test location written");

	property p_chip_id;
		@(posedge i_clk) disable iff (!i_arst_n)
		(i_addr == `MEA_A_CHIP0) |-> (o_rdata == CHIP_ID0);
	endproperty
	a_chip_id: assert property (p_chip_id) else $error("chip id mismatch");

endmodule : mea_cfg_space

// file: hdl/mea_mdio_slave.sv
// Purpose: Management serial slave with extended access to the configuration space
// Assumes: MDC and MDIO are asynchronous pins, sampled by i_clk at 250 MHz
// Notes:   MDC must stay well below i_clk/4 so every edge is seen
`timescale 1ns/1ps
`include "mea_regs.svh"
module mea_mdio_slave (
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_mdc,
	input  wire logic                 i_mdio,
	output logic                      o_mdio,
	output logic                      o_mdio_oe_n,
	output logic                      o_std_rd,
	output logic                      o_std_wr,
	output mea_pkg::mea_std_req_t     o_std_req,
	input  wire logic          [15:0] i_std_rdata,
	input  wire logic          [7:0]  i_hw_addr,
	output logic               [7:0]  o_hw_data
);
	import mea_pkg::*;

	mea_slv_t   q;
	mea_slv_t   n;
	logic [7:0] ext_addr;
	logic [7:0] rf_rdata;
	logic       rise;
	logic       bit_in;
	logic [11:0] hdr_new;

	function automatic logic ext_sel(input logic [11:0] h);
		ext_sel = (h[`MEA_HDR_SEL] == `MEA_EXT_SEL);
	endfunction : ext_sel

	function automatic logic std_ok(input logic [4:0] r);
		std_ok = (r <= `MEA_STD_MAX) || (r == `MEA_STD_C1) || (r == `MEA_STD_C2);
	endfunction : std_ok

	// Edge found from the second and third sync stages, never the first
	assign rise     = q.mdc_sy[1] && !q.mdc_sy[2];
	assign bit_in   = q.dio_sy[1];
	assign hdr_new  = {q.hdr[10:0], bit_in};
	assign ext_addr = {q.hdr[`MEA_HDR_PHY_HI], q.hdr[`MEA_HDR_PHY_LO], q.hdr[`MEA_HDR_REG]};

	mea_cfg_space mea_cfg_space_i (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_addr    (ext_addr),
		.i_wr      (q.ext_wr),
		.i_wdata   (q.sh[7:0]),
		.o_rdata   (rf_rdata),
		.i_hw_addr (i_hw_addr),
		.o_hw_data (o_hw_data)
	);

	always_comb begin
		n        = q;
		n.mdc_sy = {q.mdc_sy[1:0], i_mdc};
		n.dio_sy = {q.dio_sy[0], i_mdio};
		n.std_rd = 1'b0;
		n.std_wr = 1'b0;
		n.ext_wr = 1'b0;
		if (rise) begin
			case (q.st)
				st_pre: begin
					if (bit_in) begin
						if (q.pre_cnt != `MEA_PRE_LEN) n.pre_cnt = q.pre_cnt + 6'h01;
					end else if (q.pre_cnt == `MEA_PRE_LEN) begin
						n.pre_cnt = '0;
						n.st      = st_sof;
					end else begin
						n.pre_cnt = '0;
					end
				end
				st_sof: begin
					n.bit_cnt = '0;
					n.st      = bit_in ? st_hdr : st_pre;
				end
				st_hdr: begin
					n.hdr     = hdr_new;
					n.bit_cnt = q.bit_cnt + 4'h1;
					if (q.bit_cnt == `MEA_HDR_LAST) begin
						n.bit_cnt = '0;
						n.is_rd   = (hdr_new[`MEA_HDR_OP] == `MEA_OP_RD);
						n.is_ext  = ext_sel(hdr_new);
						if ((hdr_new[`MEA_HDR_OP] == `MEA_OP_RD || hdr_new[`MEA_HDR_OP] == `MEA_OP_WR) &&
						    (ext_sel(hdr_new) || std_ok(hdr_new[`MEA_HDR_REG]))) begin
							n.st     = st_ta1;
							n.std_rd = !ext_sel(hdr_new) && (hdr_new[`MEA_HDR_OP] == `MEA_OP_RD);
						end else begin
							n.st = st_pre;
						end
					end
				end
				st_ta1: begin
					if (q.is_rd) begin
						// Controller has released the line; take the zero slot now
						n.drv  = 1'b1;
						n.dout = 1'b0;
						n.sh   = q.is_ext ? {`MEA_HI_ZERO, rf_rdata} : i_std_rdata;
						n.st   = st_ta2;
					end else begin
						n.st = bit_in ? st_ta2 : st_pre;
					end
				end
				st_ta2: begin
					if (q.is_rd) begin
						n.dout = q.sh[15];
						n.sh   = {q.sh[14:0], 1'b0};
						n.st   = st_dat;
					end else begin
						n.st = bit_in ? st_pre : st_dat;
					end
				end
				st_dat: begin
					n.bit_cnt = q.bit_cnt + 4'h1;
					if (q.is_rd) begin
						if (q.bit_cnt == `MEA_DAT_LAST) begin
							n.drv  = 1'b0;
							n.dout = 1'b0;
							n.st   = st_pre;
						end else begin
							n.dout = q.sh[15];
							n.sh   = {q.sh[14:0], 1'b0};
						end
					end else begin
						n.sh = {q.sh[14:0], bit_in};
						if (q.bit_cnt == `MEA_DAT_LAST) begin
							n.ext_wr = q.is_ext;
							n.std_wr = !q.is_ext;
							n.st     = st_pre;
						end
					end
				end
				default: begin
					n.st   = st_pre;
					n.drv  = 1'b0;
					n.dout = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q       <= '0;
			q.st    <= st_pre;
		end else begin
			q <= n;
		end
	end

	assign o_mdio           = q.dout;
	assign o_mdio_oe_n      = !q.drv;
	assign o_std_rd         = q.std_rd;
	assign o_std_wr         = q.std_wr;
	assign o_std_req.phy    = q.hdr[`MEA_HDR_PHY];
	assign o_std_req.regad  = q.hdr[`MEA_HDR_REG];
	assign o_std_req.wdata  = q.sh;

	property p_ta_zero;
		@(posedge i_clk) disable iff (!i_arst_n)
		(rise && q.st == st_ta1 && q.is_rd) |=> (q.drv && !q.dout && q.st == st_ta2);
	endproperty
	a_ta_zero: assert property (p_ta_zero) else $error("no driven zero in turnaround");

	property p_hi_zero;
		@(posedge i_clk) disable iff (!i_arst_n)
		(q.st == st_dat && q.is_rd && q.is_ext && q.bit_cnt < `MEA_DAT_LOW) |-> (q.drv && !q.dout);
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper read byte not zero");

	property p_ext_rd_dec;
		@(posedge i_clk) disable iff (!i_arst_n)
		(q.st == st_ta1 && q.is_rd && q.is_ext) |-> (q.hdr[`MEA_HDR_OP] == `MEA_OP_RD && ext_sel(q.hdr));
	endproperty
	a_ext_rd_dec: assert property (p_ext_rd_dec) else $error("bad extended read decode");

	property p_ext_wr_dec;
		@(posedge i_clk) disable iff (!i_arst_n)
		q.ext_wr |-> (q.hdr[`MEA_HDR_OP] == `MEA_OP_WR && ext_sel(q.hdr) && !q.is_rd);
	endproperty
	a_ext_wr_dec: assert property (p_ext_wr_dec) else $error("bad extended write decode");

	property p_sof_abort;
		@(posedge i_clk) disable iff (!i_arst_n)
		(rise && q.st == st_sof && !bit_in) |=> (q.st == st_pre && q.pre_cnt == '0);
	endproperty
	a_sof_abort: assert property (p_sof_abort) else $error("bad start not abandoned");

	property p_wr_ta_abort;
		@(posedge i_clk) disable iff (!i_arst_n)
		(rise && q.st == st_ta1 && !q.is_rd && !bit_in) |=> (q.st == st_pre && !q.drv);
	endproperty
	a_wr_ta_abort: assert property (p_wr_ta_abort) else $error("bad turnaround not abandoned");

	property p_std_only;
		@(posedge i_clk) disable iff (!i_arst_n)
		(o_std_rd || o_std_wr) |-> (!ext_sel(q.hdr) && std_ok(q.hdr[`MEA_HDR_REG]));
	endproperty
	a_std_only: assert property (p_std_only) else $error("standard access outside its set");

	property p_drive_on_edge;
		@(posedge i_clk) disable iff (!i_arst_n)
		($changed(q.dout) || $changed(q.drv)) |-> $past(rise);
	endproperty
	a_drive_on_edge: assert property (p_drive_on_edge) else $error("drive changed off edge");

	c_ext_rd: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		(q.st == st_dat && q.is_rd && q.is_ext && rise && q.bit_cnt == `MEA_DAT_LAST));
	c_ext_wr: cover property (@(posedge i_clk) disable iff (!i_arst_n) q.ext_wr);
	c_std_rd: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_std_rd);
	c_abort: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		(rise && q.st == st_ta1 && !q.is_rd && !bit_in));

endmodule : mea_mdio_slave

// file: hdl/mea_pkg.sv
// Purpose: Types for the extended management access block
// Assumes: Constants live in mea_regs.svh
// Notes:   State machine codes are one-hot
package mea_pkg;

	typedef enum logic [5:0] {
		st_pre = 6'h01,
		st_sof = 6'h02,
		st_hdr = 6'h04,
		st_ta1 = 6'h08,
		st_ta2 = 6'h10,
		st_dat = 6'h20
	} mea_state_t;

	typedef enum logic [3:0] {
		rg_chip, rg_glb, rg_pwr, rg_pctl, rg_ptst, rg_pstat, rg_rsvd, rg_sta,
		rg_ictl, rg_idat, rg_pint, rg_glx, rg_self, rg_queue, rg_tos, rg_xctl
	} mea_region_t;

	typedef struct packed {
		logic [4:0]  phy;
		logic [4:0]  regad;
		logic [15:0] wdata;
	} mea_std_req_t;

	typedef struct packed {
		logic [2:0]  mdc_sy;
		logic [1:0]  dio_sy;
		mea_state_t  st;
		logic [5:0]  pre_cnt;
		logic [3:0]  bit_cnt;
		logic [11:0] hdr;
		logic [15:0] sh;
		logic        is_rd;
		logic        is_ext;
		logic        drv;
		logic        dout;
		logic        std_rd;
		logic        std_wr;
		logic        ext_wr;
	} mea_slv_t;

	typedef struct packed {
		logic [255:0][7:0] mem;
	} mea_rf_t;

endpackage : mea_pkg

// file: hdl/mea_regs.svh
// Purpose: Constants for the extended management access block
// Assumes: Included by bare name from hdl/
// Notes:   Definitions only
`ifndef MEA_REGS_SVH
`define MEA_REGS_SVH

`define MEA_OP_RD      2'h2
`define MEA_OP_WR      2'h1
`define MEA_EXT_SEL    2'h3
`define MEA_PRE_LEN    6'h20
`define MEA_HDR_LAST   4'hB
`define MEA_DAT_LAST   4'hF
`define MEA_DAT_LOW    4'h8
`define MEA_HDR_OP     11:10
`define MEA_HDR_PHY    9:5
`define MEA_HDR_SEL    7:6
`define MEA_HDR_PHY_HI 9:8
`define MEA_HDR_PHY_LO 5
`define MEA_HDR_REG    4:0
`define MEA_STD_MAX    5'h05
`define MEA_STD_C1     5'h1D
`define MEA_STD_C2     5'h1F
`define MEA_HI_ZERO    8'h00

`define MEA_A_CHIP_END 8'h01
`define MEA_A_GLB_END  8'h0D
`define MEA_A_PWR_END  8'h0F
`define MEA_A_PORT_END 8'h5F
`define MEA_A_PCTL_END 4'h4
`define MEA_A_PTST_END 4'h7
`define MEA_A_RSV0_END 8'h67
`define MEA_A_STA_END  8'h6D
`define MEA_A_ICTL_END 8'h6F
`define MEA_A_IDAT_END 8'h78
`define MEA_A_RSV1_END 8'h7B
`define MEA_A_PINT_END 8'h7D
`define MEA_A_RSV2_END 8'h7F
`define MEA_A_GLX_END  8'h87
`define MEA_A_SELFTEST 8'h88
`define MEA_A_QUEUE_END 8'h8F
`define MEA_A_TOS_END  8'h9F
`define MEA_A_RSV3_END 8'hAF
`define MEA_A_XTST_NIB 4'hF
`define MEA_A_CHIP0    8'h00

`endif

// file: test/mdio_extended_register_access_bench.sv
// Purpose: Self-checking bench for the extended management access slave
// Assumes: Controller model on the link, small responder on the standard side
// Notes:   Identification values are the arbitrary defaults of the space
`timescale 1ns/1ps
module mdio_extended_register_access_bench;
	import mea_pkg::*;
	localparam logic [7:0]  MAP_A [12] = '{8'h00, 8'h01, 8'h02, 8'h0F, 8'h15, 8'h1F,
		8'h60, 8'h6D, 8'h7C, 8'h88, 8'hBF, 8'hFE};
	localparam logic [11:0] MAP_RW     = 12'hBAC;
	localparam logic [7:0]  ID0        = 8'hA5; // Arbitrary value
	localparam logic [7:0]  ID1        = 8'h10; // Arbitrary value
	logic                   clk;
	logic                   arst_n;
	logic                   mdc;
	logic                   ctl_mdio;
	logic                   ctl_oe_n;
	logic                   dev_mdio;
	logic                   dev_oe_n;
	logic                   std_rd;
	logic                   std_wr;
	mea_std_req_t           std_req;
	mea_std_req_t           std_seen;
	logic            [15:0] std_rdata;
	logic            [7:0]  hw_addr;
	logic            [7:0]  hw_data;
	wire                    mdio_w;
	int                     mismatches;
	int                     checks_done;
	int                     std_rd_cnt;
	int                     std_wr_cnt;
	int                     cyc;

	// Pull-up wins when neither side drives
	assign mdio_w = !dev_oe_n ? dev_mdio : (!ctl_oe_n ? ctl_mdio : 1'b1);

	mea_mdio_slave mea_mdio_slave_i (.i_clk(clk), .i_arst_n(arst_n), .i_mdc(mdc), .i_mdio(mdio_w),
		.o_mdio(dev_mdio), .o_mdio_oe_n(dev_oe_n), .o_std_rd(std_rd), .o_std_wr(std_wr),
		.o_std_req(std_req), .i_std_rdata(std_rdata), .i_hw_addr(hw_addr), .o_hw_data(hw_data));
	mea_ctl_model mea_ctl_model_i (.i_clk(clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(ctl_mdio),
		.o_mdio_oe_n(ctl_oe_n));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (std_rd) begin
			std_rd_cnt++;
			std_seen <= std_req;
			std_rdata <= #1 {8'hC3, 3'h0, std_req.regad};
		end
		if (std_wr) begin
			std_wr_cnt++;
			std_seen <= std_req;
		end
		if (cyc == 80000) begin
			mismatches++;
			$display("MISMATCH timeout expected idle seen busy");
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic ext_wr(input logic [7:0] a, input logic [15:0] d);
		logic [1:0]  ta;
		logic [15:0] rd;
		mea_ctl_model_i.frame(2'h1, 2'h1, {a[7:6], 2'h3, a[5]}, a[4:0], 2'h2, d, ta, rd);
	endtask : ext_wr

	task automatic ext_rd(input logic [7:0] a, output logic [1:0] ta, output logic [15:0] rd);
		mea_ctl_model_i.frame(2'h1, 2'h2, {a[7:6], 2'h3, a[5]}, a[4:0], 2'h0, 16'h0000, ta, rd);
	endtask : ext_rd

	task automatic t_reset();
		chk("oe_n", 16'h0001, {15'h0000, dev_oe_n});
		chk("hw_data", 16'h0000, {8'h00, hw_data});
		$display("test reset done");
	endtask : t_reset

	// Writes everything first so an aliased address shows up on read-back
	task automatic t_map();
		logic [1:0]  ta;
		logic [15:0] rd;
		logic [7:0]  e;
		for (int i = 0; i < 12; i++) ext_wr(MAP_A[i], {~MAP_A[i], MAP_A[i] ^ 8'hC3});
		for (int i = 0; i < 12; i++) begin
			e = MAP_RW[i] ? (MAP_A[i] ^ 8'hC3) : (i == 0 ? ID0 : (i == 1 ? ID1 : 8'h00));
			ext_rd(MAP_A[i], ta, rd);
			chk("ta", 16'h0002, {14'h0000, ta});
			chk("rdata", {8'h00, e}, rd);
			hw_addr = MAP_A[i];
			#1;
			if (MAP_RW[i]) chk("hw_data", {8'h00, e}, {8'h00, hw_data});
		end
		$display("test map done");
	endtask : t_map

	task automatic t_std();
		logic [1:0]  ta;
		logic [15:0] rd;
		logic [4:0]  regs [4] = '{5'h00, 5'h05, 5'h1D, 5'h1F};
		chk("std_rd_cnt", 16'h0000, std_rd_cnt[15:0]);
		foreach (regs[i]) begin
			mea_ctl_model_i.frame(2'h1, 2'h2, 5'h01, regs[i], 2'h0, 16'h0000, ta, rd);
			chk("std_phy", 16'h0001, {11'h000, std_seen.phy});
			chk("std_rdata", {8'hC3, 3'h0, regs[i]}, rd);
		end
		mea_ctl_model_i.frame(2'h1, 2'h1, 5'h02, 5'h04, 2'h2, 16'hBEEF, ta, rd);
		chk("std_wr_cnt", 16'h0001, std_wr_cnt[15:0]);
		chk("std_wdata", 16'hBEEF, std_seen.wdata);
		chk("std_regad", 16'h0004, {11'h000, std_seen.regad});
		mea_ctl_model_i.frame(2'h1, 2'h2, 5'h01, 5'h07, 2'h0, 16'h0000, ta, rd);
		chk("std_refused", 16'hFFFF, rd);
		chk("std_rd_cnt", 16'h0004, std_rd_cnt[15:0]);
		$display("test standard done");
	endtask : t_std

	task automatic t_abort();
		logic [1:0]  ta;
		logic [15:0] rd;
		mea_ctl_model_i.frame(2'h1, 2'h1, 5'h06, 5'h03, 2'h3, 16'h005A, ta, rd);
		mea_ctl_model_i.frame(2'h0, 2'h1, 5'h06, 5'h03, 2'h2, 16'h005A, ta, rd);
		mea_ctl_model_i.frame(2'h1, 2'h0, 5'h06, 5'h03, 2'h2, 16'h005A, ta, rd);
		ext_rd(8'h03, ta, rd);
		chk("abort_rdata", 16'h0000, rd);
		chk("abort_std_wr", 16'h0001, std_wr_cnt[15:0]);
		ext_wr(8'h03, 16'hA55A);
		ext_rd(8'h03, ta, rd);
		chk("recover_rdata", 16'h005A, rd);
		$display("test abort done");
	endtask : t_abort

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	initial begin
		arst_n = 1'b0;
		std_rdata = 16'h0000;
		hw_addr = 8'h00;
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_reset();
		t_map();
		t_std();
		t_abort();
		end_sim();
	end
endmodule : mdio_extended_register_access_bench

// file: test/mea_ctl_model.sv
// Purpose: Management controller model that drives MDC and MDIO frames
// Assumes: Line has a pull-up; the bench resolves the wire and feeds i_mdio
// Notes:   MDC stands low between frames; MDIO changes only while MDC is low
`timescale 1ns/1ps
module mea_ctl_model (
	input  wire logic i_clk,
	input  wire logic i_mdio,
	output logic      o_mdc,
	output logic      o_mdio,
	output logic      o_mdio_oe_n
);
	// Half period in i_clk cycles, 40 ns; the 80 ns period is quicker than a real controller may run, which stresses the sync
	localparam int HALF = 10;

	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b0;
		o_mdio_oe_n = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick

	// Line is sampled just before the rise, so a device bit launched by the previous rise has settled
	task automatic bit_io(input logic b, input logic drive, output logic seen);
		o_mdc = 1'b0;
		o_mdio = drive ? b : ~o_mdio;
		o_mdio_oe_n = ~drive;
		tick(HALF);
		seen = i_mdio;
		o_mdc = 1'b1;
		tick(HALF);
	endtask : bit_io

	task automatic frame(input logic [1:0] sof, input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] regad, input logic [1:0] ta, input logic [15:0] wd,
		output logic [1:0] rta, output logic [15:0] rd);
		logic [13:0] hdr;
		logic        rdf;
		logic        s;
		hdr = {sof, op, phy, regad};
		rdf = (op == 2'h2);
		tick(1);
		repeat (32) bit_io(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
		for (int i = 1; i >= 0; i--) begin
			bit_io(ta[i], ~rdf, s);
			rta[i] = s;
		end
		for (int i = 15; i >= 0; i--) begin
			bit_io(wd[i], ~rdf, s);
			rd[i] = s;
		end
		o_mdc = 1'b0;
		o_mdio_oe_n = 1'b1;
		tick(2 * HALF);
	endtask : frame
endmodule : mea_ctl_model
